// [rtl/jisp_map.svh]
// Instruction codes, register offsets and timing figures for the JTAG programming block
`ifndef JISP_MAP_SVH
`define JISP_MAP_SVH
`define JISP_IR_W        10
`define JISP_IR_RESET    10'h001
`define JISP_IR_USER_A   10'h00c
`define JISP_IR_USER_B   10'h00e
`define JISP_IR_IDCODE   10'h006
`define JISP_IR_BYPASS   10'h3ff
`define JISP_IR_ENTER    10'h2cc
`define JISP_IR_EXIT     10'h201
`define JISP_IR_ERASE    10'h2f2
`define JISP_IR_PROGRAM  10'h2f4
`define JISP_IR_VERIFY   10'h205
`define JISP_IR_CLAMP    10'h2cd
`define JISP_IR_RECONF   10'h2a5
`define JISP_A_CTRL      8'h00
`define JISP_A_CLAMP     8'h04
`define JISP_A_STATUS    8'h08
`define JISP_A_IR        8'h0c
`define JISP_A_ID        8'h10
`define JISP_CLK_MHZ     100
`define JISP_TCK_MAX_MHZ 18
`define JISP_ERASE_MS    500
`define JISP_PROG_US     75
`define JISP_RECONF_US   100
`endif

// [rtl/jisp_pkg.sv]
// Types shared by the JTAG programming block
package jisp_pkg;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR     = 16'h0010, EX1_DR   = 16'h0020, PA_DR  = 16'h0040, EX2_DR = 16'h0080,
    UP_DR     = 16'h0100, SEL_IR   = 16'h0200, CAP_IR = 16'h0400, SH_IR  = 16'h0800,
    EX1_IR    = 16'h1000, PA_IR    = 16'h2000, EX2_IR = 16'h4000, UP_IR  = 16'h8000
  } jisp_tap_type;
  typedef enum logic [1:0] {
    CL_Z = 2'h0, CL_HOLD = 2'h1, CL_HIGH = 2'h2, CL_LOW = 2'h3
  } jisp_clamp_type;
endpackage

// [rtl/jisp_sync.sv]
// Two-flop synchroniser for inputs from outside the hclk domain
`timescale 1ns/1ps
module jisp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // jisp_sync

// [rtl/jisp_shreg.sv]
// Capture-and-shift register, LSB out first, new bits enter at the MSB
`timescale 1ns/1ps
module jisp_shreg #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         cap,
  input  wire logic [W-1:0] cap_val,
  input  wire logic         shift,
  input  wire logic         sin,
  output logic      [W-1:0] q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (cap) begin
      q <= cap_val;
    end else if (shift) begin
      q <= {sin, q[W-1:1]};
    end
  end
endmodule // jisp_shreg

// [rtl/jisp_top.sv]
// JTAG test access port with flash programming sequencer and I/O pin control
`timescale 1ns/1ps
`include "jisp_map.svh"

// What this block does
// - User scan instructions route TDI through user logic and expose TAP state.
// - Each user instruction selects its own separate user chain.
// - Commands, addresses, data shift in on TDI; read-back shifts out on TDO.
// - Entering and leaving programming moves pins over without glitches.
// - Erase pulse runs while the TAP waits 500 ms in Run-Test/Idle.
// - Program pulse runs while the TAP waits 75 us in Run-Test/Idle.
// - Verify reads the addressed word and presents it for shifting out.
// - During programming outside real-time mode, every unclamped pin is tri-stated with a weak pull-up.
// - Completion bit is written last; pins never drive unless the last image load found it set.
// - Clamp instruction holds, drives high, low, or floats each pin separately.
// - Real-time mode rewrites configuration flash while the design keeps running.
// - New image loads at power-up or on a reconfiguration command.
// - During reconfiguration pins stay tri-stated with pull-ups throughout.
// - Interface works with a test clock up to 18 MHz.
// - Configuration flash and each user flash sector are handled independently.
// - The instruction register is 10 bits long for every instruction.
// - User chain instructions are codes 0x00c and 0x00e.
module jisp_top import jisp_pkg::*; #(
  parameter int          N_PINS     = 8,
  parameter int          AW         = 7,
  parameter int          DW         = 16,
  parameter int          ERASE_CYC  = `JISP_ERASE_MS * 1000 * `JISP_CLK_MHZ,
  parameter int          PROG_CYC   = `JISP_PROG_US * `JISP_CLK_MHZ,
  parameter int          RECONF_CYC = `JISP_RECONF_US * `JISP_CLK_MHZ,
  parameter logic        DONE_INIT  = 1'b1,
  // Arbitrary identity value; only the LSB of 1 is fixed by the scan convention
  parameter logic [31:0] SILICON_ID = 32'h0a5c_3001
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // JTAG pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  // User scan chains in the logic array
  input  wire logic              user_tdo_a,
  input  wire logic              user_tdo_b,
  output logic                   user_chain_select_a,
  output logic                   user_chain_select_b,
  output logic                   user_chain_tdi,
  output logic                   user_tck_rise,
  output logic [15:0]            user_tap_state,
  // User design outputs and the device pins
  input  wire logic [N_PINS-1:0] core_out,
  input  wire logic [N_PINS-1:0] core_oe,
  output logic      [N_PINS-1:0] pin_out,
  output logic      [N_PINS-1:0] pin_oe,
  output logic      [N_PINS-1:0] pin_pullup,
  // Status
  output logic                   logic_running
);
  localparam int DRW = 1 + AW + DW;
  // 18 MHz gives a TCK half period of at least this many hclk cycles
  localparam int TCK_HALF_CYC = `JISP_CLK_MHZ / (2 * `JISP_TCK_MAX_MHZ);

  jisp_tap_type          tap_q, tap_d;
  logic [2:0]            pin_s;
  logic                  tck_s, tms_s, tdi_s, tck_prev_q, tck_rise, tck_fall;
  logic [`JISP_IR_W-1:0] ir_q, ir_sh_q;
  logic [31:0]           id_sh_q;
  logic [DRW-1:0]        isp_sh_q, isp_cap;
  logic                  bypass_q, sel_user_a, sel_user_b, sel_id, sel_isp, dr_out;
  logic                  isp_q, realtime_q, clamp_q, done_q, running_q, boot_q;
  logic                  ctrl_realtime_q, tgt_q, rd_tgt_q;
  logic [AW-1:0]         addr_q;
  logic [DW-1:0]         data_q, rd_word;
  logic [DW-1:0]         cfg_flash [2**AW];
  logic [DW-1:0]         user_flash [2**AW];
  logic [31:0]           cnt_q, pulse_len;
  logic                  fired_q, pulse_arm, pulse_fire, ir_upd;
  logic [31:0]           reconf_cnt_q;
  logic                  reconf_busy_q;
  logic [N_PINS-1:0]     hold_out_q, hold_oe_q, pin_out_d, pin_oe_d, pin_pull_d;
  logic [2*N_PINS-1:0]   clamp_cfg_q;
  logic                  ahb_wr_q;
  logic [7:0]            ahb_addr_q;
  logic [31:0]           rd_mux;

  // Pins are synchronised; TCK is sampled and its edges found in the hclk domain
  jisp_sync #(.W(3)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({tck, tms, tdi}),
    .q     (pin_s)
  );
  assign {tck_s, tms_s, tdi_s} = pin_s;
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_prev_q <= 1'b0;
      tap_q      <= TAP_RESET;
    end else begin
      tck_prev_q <= tck_s;
      tap_q      <= tap_d;
    end
  end

  always_comb begin
    tap_d = tap_q;
    if (tck_rise) begin
      case (tap_q)
        TAP_RESET: tap_d = tms_s ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:  tap_d = tms_s ? SEL_DR : TAP_IDLE;
        SEL_DR:    tap_d = tms_s ? SEL_IR : CAP_DR;
        CAP_DR:    tap_d = tms_s ? EX1_DR : SH_DR;
        SH_DR:     tap_d = tms_s ? EX1_DR : SH_DR;
        EX1_DR:    tap_d = tms_s ? UP_DR : PA_DR;
        PA_DR:     tap_d = tms_s ? EX2_DR : PA_DR;
        EX2_DR:    tap_d = tms_s ? UP_DR : SH_DR;
        UP_DR:     tap_d = tms_s ? SEL_DR : TAP_IDLE;
        SEL_IR:    tap_d = tms_s ? TAP_RESET : CAP_IR;
        CAP_IR:    tap_d = tms_s ? EX1_IR : SH_IR;
        SH_IR:     tap_d = tms_s ? EX1_IR : SH_IR;
        EX1_IR:    tap_d = tms_s ? UP_IR : PA_IR;
        PA_IR:     tap_d = tms_s ? EX2_IR : PA_IR;
        EX2_IR:    tap_d = tms_s ? UP_IR : SH_IR;
        UP_IR:     tap_d = tms_s ? SEL_DR : TAP_IDLE;
        default:   tap_d = TAP_RESET;
      endcase
    end
  end

  // Instruction register, always the full width
  jisp_shreg #(.W(`JISP_IR_W)) u_ir_sh (
    .clk     (hclk),
    .rst_n   (hresetn),
    .cap     (tck_rise && tap_q == CAP_IR),
    .cap_val (`JISP_IR_RESET),
    .shift   (tck_rise && tap_q == SH_IR),
    .sin     (tdi_s),
    .q       (ir_sh_q)
  );

  assign ir_upd = tck_rise && tap_q == UP_IR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_q <= `JISP_IR_IDCODE;
    end else if (tap_q == TAP_RESET) begin
      ir_q <= `JISP_IR_IDCODE;
    end else if (ir_upd) begin
      ir_q <= ir_sh_q;
    end
  end

  assign sel_user_a = ir_q == `JISP_IR_USER_A;
  assign sel_user_b = ir_q == `JISP_IR_USER_B;
  assign sel_id     = ir_q == `JISP_IR_IDCODE;
  assign sel_isp    = ir_q == `JISP_IR_ENTER || ir_q == `JISP_IR_EXIT || ir_q == `JISP_IR_ERASE
                   || ir_q == `JISP_IR_PROGRAM || ir_q == `JISP_IR_VERIFY
                   || ir_q == `JISP_IR_CLAMP || ir_q == `JISP_IR_RECONF;

  jisp_shreg #(.W(32)) u_id_sh (
    .clk     (hclk),
    .rst_n   (hresetn),
    .cap     (tck_rise && tap_q == CAP_DR && sel_id),
    .cap_val (SILICON_ID),
    .shift   (tck_rise && tap_q == SH_DR && sel_id),
    .sin     (tdi_s),
    .q       (id_sh_q)
  );

  // Verify captures the stored word of the latched address
  assign rd_word = tgt_q ? user_flash[addr_q] : cfg_flash[addr_q];
  assign isp_cap = (ir_q == `JISP_IR_VERIFY && isp_q) ? {tgt_q, addr_q, rd_word} : isp_sh_q;

  jisp_shreg #(.W(DRW)) u_isp_sh (
    .clk     (hclk),
    .rst_n   (hresetn),
    .cap     (tck_rise && tap_q == CAP_DR && sel_isp),
    .cap_val (isp_cap),
    .shift   (tck_rise && tap_q == SH_DR && sel_isp),
    .sin     (tdi_s),
    .q       (isp_sh_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_q  <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else if (tck_rise && tap_q == UP_DR && sel_isp) begin
      {tgt_q, addr_q, data_q} <= isp_sh_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bypass_q <= 1'b0;
    end else if (tck_rise && tap_q == CAP_DR) begin
      bypass_q <= 1'b0;
    end else if (tck_rise && tap_q == SH_DR) begin
      bypass_q <= tdi_s;
    end
  end

  always_comb begin
    case (1'b1)
      sel_user_a: dr_out = user_tdo_a;
      sel_user_b: dr_out = user_tdo_b;
      sel_id:     dr_out = id_sh_q[0];
      sel_isp:    dr_out = isp_sh_q[0];
      default:    dr_out = bypass_q;
    endcase
  end

  // TDO changes on the falling TCK edge so the programmer samples it settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (tap_q == SH_IR) ? ir_sh_q[0] : dr_out;
      tdo_oe <= tap_q == SH_IR || tap_q == SH_DR;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_chain_select_a <= 1'b0;
      user_chain_select_b <= 1'b0;
      user_chain_tdi      <= 1'b0;
      user_tck_rise       <= 1'b0;
      user_tap_state      <= TAP_RESET;
    end else begin
      user_chain_select_a <= sel_user_a;
      user_chain_select_b <= sel_user_b;
      user_chain_tdi      <= tdi_s;
      user_tck_rise       <= tck_rise;
      user_tap_state      <= tap_q;
    end
  end

  // Programming mode, real-time option and clamp, switched at instruction update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isp_q      <= 1'b0;
      realtime_q <= 1'b0;
      clamp_q    <= 1'b0;
      hold_out_q <= '0;
      hold_oe_q  <= '0;
    end else if (tap_q == TAP_RESET) begin
      isp_q   <= 1'b0;
      clamp_q <= 1'b0;
    end else if (ir_upd) begin
      if (ir_sh_q == `JISP_IR_ENTER && !isp_q) begin
        isp_q      <= 1'b1;
        realtime_q <= ctrl_realtime_q;
        hold_out_q <= core_out;
        hold_oe_q  <= core_oe;
      end else if (ir_sh_q == `JISP_IR_CLAMP && isp_q) begin
        clamp_q <= 1'b1;
      end else if (ir_sh_q == `JISP_IR_EXIT || ir_sh_q == `JISP_IR_RECONF) begin
        isp_q   <= 1'b0;
        clamp_q <= 1'b0;
      end
    end
  end

  // Pulse length follows the instruction; leaving Run-Test/Idle early aborts it
  always_comb begin
    case (ir_q)
      `JISP_IR_ERASE:   pulse_len = 32'(ERASE_CYC);
      `JISP_IR_PROGRAM: pulse_len = 32'(PROG_CYC);
      default:          pulse_len = '0;
    endcase
  end
  assign pulse_arm  = isp_q && tap_q == TAP_IDLE && pulse_len != '0 && !fired_q;
  assign pulse_fire = pulse_arm && cnt_q == pulse_len - 32'd1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q   <= '0;
      fired_q <= 1'b0;
    end else if (tap_q != TAP_IDLE) begin
      cnt_q   <= '0;
      fired_q <= 1'b0;
    end else if (pulse_fire) begin
      cnt_q   <= '0;
      fired_q <= 1'b1;
    end else if (pulse_arm) begin
      cnt_q <= cnt_q + 32'd1;
    end
  end

  // Flash arrays keep contents over reset; bits only clear when programmed
  always_ff @(posedge hclk) begin
    if (pulse_fire && ir_q == `JISP_IR_ERASE) begin
      for (int i = 0; i < 2**AW; i++) begin
        if (!tgt_q) begin
          cfg_flash[i] <= '1;
        end else if (i[AW-1] == addr_q[AW-1]) begin
          user_flash[i] <= '1;
        end
      end
    end else if (pulse_fire && ir_q == `JISP_IR_PROGRAM) begin
      if (!tgt_q) begin
        cfg_flash[addr_q] <= cfg_flash[addr_q] & data_q;
      end else begin
        user_flash[addr_q] <= user_flash[addr_q] & data_q;
      end
    end
  end

  // The top configuration address is written last and carries the completion bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= DONE_INIT;
    end else if (pulse_fire && !tgt_q && ir_q == `JISP_IR_ERASE) begin
      done_q <= 1'b0;
    end else if (pulse_fire && !tgt_q && ir_q == `JISP_IR_PROGRAM && addr_q == '1) begin
      done_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_q        <= 1'b1;
      running_q     <= 1'b0;
      reconf_busy_q <= 1'b0;
      reconf_cnt_q  <= '0;
    end else if (boot_q) begin
      boot_q    <= 1'b0;
      running_q <= done_q;
    end else if (ir_upd && ir_sh_q == `JISP_IR_RECONF && isp_q) begin
      reconf_busy_q <= 1'b1;
      running_q     <= 1'b0;
      reconf_cnt_q  <= '0;
    end else if (reconf_busy_q) begin
      if (reconf_cnt_q == 32'(RECONF_CYC) - 32'd1) begin
        reconf_busy_q <= 1'b0;
        running_q     <= done_q;
      end else begin
        reconf_cnt_q <= reconf_cnt_q + 32'd1;
      end
    end
  end
  assign logic_running = running_q;

  // Pin control; registered so every mode change is a single clean edge
  always_comb begin
    pin_out_d  = '0;
    pin_oe_d   = '0;
    pin_pull_d = '1;
    for (int i = 0; i < N_PINS; i++) begin
      if (reconf_busy_q) begin
        pin_pull_d[i] = 1'b1;
      end else if (isp_q && !realtime_q) begin
        // Clamped drive waits for a loaded image so an unfinished run stays quiet
        if (clamp_q && running_q) begin
          case (jisp_clamp_type'(clamp_cfg_q[2*i +: 2]))
            CL_HOLD: begin
              pin_oe_d[i]   = hold_oe_q[i];
              pin_out_d[i]  = hold_out_q[i];
              pin_pull_d[i] = !hold_oe_q[i];
            end
            CL_HIGH: begin
              pin_oe_d[i]   = 1'b1;
              pin_out_d[i]  = 1'b1;
              pin_pull_d[i] = 1'b0;
            end
            CL_LOW: begin
              pin_oe_d[i]   = 1'b1;
              pin_pull_d[i] = 1'b0;
            end
            default: pin_pull_d[i] = 1'b1;
          endcase
        end else begin
          pin_pull_d[i] = 1'b1;
        end
      end else if (running_q) begin
        pin_oe_d[i]   = core_oe[i];
        pin_out_d[i]  = core_out[i];
        pin_pull_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_pullup <= '1;
    end else begin
      pin_out    <= pin_out_d;
      pin_oe     <= pin_oe_d;
      pin_pullup <= pin_pull_d;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_comb begin
    case (haddr[7:0])
      `JISP_A_CTRL:   rd_mux = {31'h0, ctrl_realtime_q};
      `JISP_A_CLAMP:  rd_mux = 32'(clamp_cfg_q);
      `JISP_A_STATUS: rd_mux = {25'h0, reconf_busy_q, cnt_q != '0, clamp_q, realtime_q,
                                isp_q, running_q, done_q};
      `JISP_A_IR:     rd_mux = {22'h0, ir_q};
      `JISP_A_ID:     rd_mux = SILICON_ID;
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_q   <= 1'b0;
      ahb_addr_q <= '0;
      hrdata     <= '0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else if (hready) begin
      ahb_wr_q   <= hsel && htrans[1] && hwrite;
      ahb_addr_q <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_realtime_q <= 1'b0;
      clamp_cfg_q     <= '0;
    end else if (ahb_wr_q) begin
      if (ahb_addr_q == `JISP_A_CTRL) begin
        ctrl_realtime_q <= hwdata[0];
      end else if (ahb_addr_q == `JISP_A_CLAMP) begin
        clamp_cfg_q <= hwdata[2*N_PINS-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_enter;
    ir_upd && ir_sh_q == `JISP_IR_ENTER && !isp_q && !ctrl_realtime_q && !reconf_busy_q;
  endsequence
  sequence s_quiet_pins;
    isp_q ##1 (pin_oe == '0 && pin_pullup == '1);
  endsequence
  property p_enter_quiet;
    s_enter |=> s_quiet_pins;
  endproperty
  a_enter_quiet: assert property (p_enter_quiet) else $error("pins not quiet");

  property p_user_tdo;
    sel_user_a && tap_q == SH_DR && tck_fall |=> tdo == $past(user_tdo_a) && tdo_oe;
  endproperty
  a_user_tdo: assert property (p_user_tdo) else $error("user chain A not on TDO");

  property p_one_chain;
    !(user_chain_select_a && user_chain_select_b);
  endproperty
  a_one_chain: assert property (p_one_chain) else $error("both user chains");

  property p_not_done_quiet;
    !running_q |=> pin_oe == '0;
  endproperty
  a_not_done_quiet: assert property (p_not_done_quiet) else $error("pin driven");

  property p_reconf_quiet;
    reconf_busy_q |=> pin_oe == '0 && pin_pullup == '1;
  endproperty
  a_reconf_quiet: assert property (p_reconf_quiet) else $error("pin drive in reconf");

  property p_idle_count;
    tap_q != TAP_IDLE |=> cnt_q == '0 && !fired_q;
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("pulse outlived idle");

  property p_done_last;
    pulse_fire && ir_q == `JISP_IR_PROGRAM && !tgt_q && addr_q == '1 |=> done_q;
  endproperty
  a_done_last: assert property (p_done_last) else $error("completion bit not set");

  property p_verify_cap;
    tck_rise && tap_q == CAP_DR && ir_q == `JISP_IR_VERIFY && isp_q
      |=> isp_sh_q[DW-1:0] == $past(rd_word);
  endproperty
  a_verify_cap: assert property (p_verify_cap) else $error("verify word lost");

  property p_ir_update;
    ir_upd |=> ir_q == $past(ir_sh_q);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not taken");

  property p_reconf_load;
    $fell(reconf_busy_q) |-> running_q == done_q;
  endproperty
  a_reconf_load: assert property (p_reconf_load) else $error("image not loaded");
endmodule // jisp_top

// [verif/jisp_prog.sv]
// Programmer model driving the test access port
`timescale 1ns/1ps
module jisp_prog (
  // Pacing clock and JTAG pins
  input  wire logic hclk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // 16 hclk per TCK keeps it at 6.25 MHz, clock idles low between frames
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge hclk);
    tms <= m;
    tdi <= d;
    repeat (7) @(posedge hclk);
    o = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge hclk);
    tck <= 1'b0;
  endtask
  // LSB first in and out, the caller compares read-back
  task automatic scan(input logic ir, input int n, input logic [31:0] v, output logic [31:0] r);
    logic o;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    r = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      r[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Rounds the pulse up to whole TCK periods plus one spare
  task automatic idle(input int cyc);
    logic o;
    repeat ((cyc + 15) / 16 + 1) step(1'b0, 1'b0, o);
  endtask
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule // jisp_prog

// [verif/test_jisp_top.sv]
// Bench for the JTAG programming block
`timescale 1ns/1ps
`include "jisp_map.svh"
module test_jisp_top;
  localparam logic [31:0] ID = 32'h1357_9bdf; // Arbitrary identity value
  logic        hclk, hresetn, hsel, hwrite, hreadyout, tck, tms, tdi, tdo, sel_a, sel_b;
  logic [1:0]  htrans;
  logic [7:0]  core_out, core_oe, pin_oe, pin_pullup, pin_out;
  logic        uta, utb;
  logic [31:0] haddr, hwdata, hrdata, r, j;
  int          miscompares, samples_checked;
  always #5 hclk = ~hclk;
  jisp_top #(.ERASE_CYC(200), .PROG_CYC(20), .RECONF_CYC(200), .SILICON_ID(ID)) u_jisp_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(), .user_tdo_a(uta), .user_tdo_b(utb),
    .user_chain_select_a(sel_a), .user_chain_select_b(sel_b), .user_chain_tdi(),
    .user_tck_rise(), .user_tap_state(), .core_out(core_out), .core_oe(core_oe),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .logic_running()
  );
  jisp_prog u_jisp_prog (.hclk(hclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    chk("hreadyout", 32'h1, 32'h0);
    end_of_test();
  endtask
  // Single word transfer; the write data follows the accepted address phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic ir(input logic [9:0] c);
    u_jisp_prog.scan(1'b1, 10, {22'h0, c}, j);
  endtask
  task automatic dr(input int n, input logic [31:0] v);
    u_jisp_prog.scan(1'b0, n, v, j);
  endtask
  task automatic pins(input logic [15:0] e);
    chk("pin_oe pin_pullup", {16'h0, e}, {16'h0, pin_oe, pin_pullup});
  endtask
  // Target and address are latched under a repeated enter, which captures no unerased word
  task automatic pulse(input logic [9:0] c, input logic [7:0] a, input logic [15:0] d, int n);
    ir(`JISP_IR_ENTER);
    dr(24, {8'h0, a, d});
    ir(c);
    u_jisp_prog.idle(n);
  endtask
  task automatic vfy(input logic [7:0] a, input logic [15:0] e);
    ir(`JISP_IR_VERIFY);
    dr(24, {8'h0, a, 16'h0});
    dr(24, {8'h0, a, 16'h0});
    chk("read-back", {16'h0, e}, {16'h0, j[15:0]});
  endtask
  task automatic id_check();
    ir(`JISP_IR_IDCODE);
    dr(32, 32'h0);
    chk("identity", ID, j);
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    core_out = 8'h5a;
    core_oe = 8'h3c;
    uta = 1'b1;
    utb = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("pin_oe", 32'(core_oe), 32'(pin_oe));
    ahb(1'b0, `JISP_A_ID, 32'h0);
    chk("id reg", ID, r);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    ahb(1'b1, `JISP_A_CLAMP, 32'h0000_e4e4);
    ahb(1'b0, `JISP_A_CLAMP, 32'h0);
    chk("clamp reg", 32'h0000_e4e4, r);
    u_jisp_prog.tap_reset();
    ir(`JISP_IR_USER_A);
    dr(4, 32'h0);
    chk("chain a", 32'h2f, {26'h0, sel_a, sel_b, j[3:0]});
    ir(`JISP_IR_USER_B);
    dr(4, 32'hf);
    chk("chain b", 32'h10, {26'h0, sel_a, sel_b, j[3:0]});
    ir(`JISP_IR_ENTER);
    pins(16'h00ff);
    id_check();
    pulse(`JISP_IR_ERASE, 8'h00, 16'h0, 200);
    pulse(`JISP_IR_ERASE, 8'h80, 16'h0, 200);
    pulse(`JISP_IR_PROGRAM, 8'h05, 16'h1234, 20);
    pulse(`JISP_IR_PROGRAM, 8'h83, 16'hbeef, 20);
    vfy(8'h05, 16'h1234);
    vfy(8'h83, 16'hbeef);
    ahb(1'b0, `JISP_A_STATUS, 32'h0);
    chk("status", 32'h4, {29'h0, r[2], 1'b0, r[0]});
    ir(`JISP_IR_RECONF);
    pins(16'h00ff);
    repeat (300) @(posedge hclk);
    chk("pin_oe", 32'h0, 32'(pin_oe));
    ir(`JISP_IR_ENTER);
    pulse(`JISP_IR_PROGRAM, 8'h7f, 16'h0, 20);
    ir(`JISP_IR_RECONF);
    repeat (300) @(posedge hclk);
    chk("pin_oe", 32'(core_oe), 32'(pin_oe));
    ahb(1'b1, `JISP_A_CTRL, 32'h1);
    ir(`JISP_IR_ENTER);
    chk("pin_oe", 32'(core_oe), 32'(pin_oe));
    ir(`JISP_IR_EXIT);
    ahb(1'b1, `JISP_A_CTRL, 32'h0);
    ir(`JISP_IR_ENTER);
    pins(16'h00ff);
    id_check();
    vfy(8'h05, 16'h1234);
    ir(`JISP_IR_CLAMP);
    pins(16'hec13);
    chk("pin_out", 32'h46, 32'(pin_out));
    ir(`JISP_IR_EXIT);
    repeat (4) @(posedge hclk);
    chk("pin_oe", 32'(core_oe), 32'(pin_oe));
    chk("pin_out", 32'(core_out), 32'(pin_out));
    end_of_test();
  end
endmodule // test_jisp_top
